// ==== dif_chain.sv ====
// Operation
// [R1] lower analog gain on early large-signal warning
// [R2] raise gain after long small envelope
// [R3] digital gain compensates every analog gain change
// [R4] autorange only when enabled and swept
// [R5] real samples become I/Q pairs, half rate
// [R6] single-stage boost inverts prefilter roll-off
// [R7] I and Q low-pass, near-Gaussian cascade
// [R8] skirt model exponent 2.12, selectivity 4.1:1
// [R9] 160 resolution widths, all digital
// [R10] decimate by selectable factor, send to host
// [R11] factor one forwards undecimated pairs
// [R12] swept mode makes magnitude and phase
// [R13] video smoothing then display detector points
// [R14] host does log/linear and scale per division
// [R15] video filter on log, volt, power; accumulator
// [R16] one-cycle valid per polar and trace output; clear on reset; iq_valid stays high until iq_ready takes the pair
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`default_nettype none
module dif_chain #(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [dif_pkg::ADC_W-1:0] adc_data,
   input wire logic adc_valid,
   output logic adc_ready,
   input wire logic env_big,
   output logic [1:0] gain_step,
   output dif_pkg::dif_iq_t iq_data,
   output logic iq_valid,
   input wire logic iq_ready,
   output dif_pkg::dif_polar_t polar,
   output logic polar_valid,
   output logic [7:0] trace_point,
   output logic trace_valid
);
   import dif_pkg::*;

   typedef struct packed {
      logic ar_en;
      logic swept;
      dif_vmode_t vmode;
      dif_det_t dmode;
      logic accum;
      logic [7:0] resolution_filter_width;
      logic [7:0] decim;
      logic [3:0] vshift;
      logic [2:0] bl;
      logic [3:0] boost;
      logic aw_got;
      logic [7:0] waddr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [1:0] gain;
      logic [AR_ALIGN-1:0][1:0] gpipe;
      logic [HOLD_W-1:0] hold;
      logic [1:0] ph;
      logic signed [ACC_W-1:0] i_hold;
      logic signed [ACC_W-1:0] bi_prev;
      logic signed [ACC_W-1:0] bq_prev;
      logic [GAUSS_N-1:0][ACC_W-1:0] gi;
      logic [GAUSS_N-1:0][ACC_W-1:0] gq;
      logic [7:0] dcnt;
      dif_polar_t pol;
      logic pvalid;
      logic [ACC_W-1:0] vfilt;
      logic [7:0] bcnt;
      logic [31:0] dacc;
      logic [7:0] trace;
      logic tvalid;
   } dif_state_t;

   dif_state_t s;
   dif_state_t next_s;
   logic fifo_in_ready;
   logic fifo_push;
   dif_iq_t fifo_in;

   // -------------------------------------------------
   // functions
   // -------------------------------------------------
   function automatic logic [31:0] reg_read(dif_state_t st,
         logic [7:0] a, logic full);
      logic [31:0] v;
      v = '0;
      case (a)
         REG_CTRL: begin
            v[CTRL_AR_EN] = st.ar_en;
            v[CTRL_SWEPT] = st.swept;
            v[CTRL_VMODE +: 2] = st.vmode;
            v[CTRL_DMODE +: 2] = st.dmode;
            v[CTRL_ACCUM] = st.accum;
         end
         REG_RBW: v[7:0] = st.resolution_filter_width;
         REG_DECIM: v[7:0] = st.decim;
         REG_VIDEO: v[3:0] = st.vshift;
         REG_BUCKET: v[2:0] = st.bl;
         REG_BOOST: v[3:0] = st.boost;
         REG_STATUS: v[3:0] = {full, st.ar_en && st.swept, st.gain};
         REG_TRACE: v[7:0] = st.trace;
         default: v = '0;
      endcase
      return v;
   endfunction

   function automatic logic reg_ok(logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= REG_TRACE);
   endfunction

   function automatic logic [31:0] wmerge(logic [31:0] old,
         logic [31:0] d, logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [7:0] log2a(logic [ACC_W-1:0] x);
      logic [4:0] e;
      logic [ACC_W-1:0] sh;
      e = '0;
      for (int k = 0; k < ACC_W; k++) begin
         if (x[k]) begin
            e = 5'(k);
         end
      end
      sh = x << (5'(ACC_W-1) - e);
      return {e, sh[ACC_W-2 -: 3]};
   endfunction

   function automatic logic [7:0] to_log(logic [ACC_W-1:0] v,
         dif_vmode_t m);
      logic [8:0] t;
      t = {1'b0, log2a(v)} + POW_LOG_OFS;
      case (m)
         VID_LOG: return v[7:0];
         VID_VOLT: return log2a(v);
         VID_POWER: return t[8:1];
         default: return log2a(v);
      endcase
   endfunction

   function automatic logic signed [ACC_W-1:0] gsmooth(
         logic signed [ACC_W-1:0] y, logic signed [ACC_W-1:0] x,
         logic [8:0] a);
      logic signed [ACC_W+10:0] d;
      logic signed [ACC_W+10:0] am;
      logic signed [ACC_W+10:0] p;
      d = (ACC_W+11)'(x) - (ACC_W+11)'(y);
      am = (ACC_W+11)'(a);
      p = d * am;
      return y + ACC_W'(p >>> ALPHA_SH);
   endfunction

   function automatic logic signed [ACC_W-1:0] boostf(
         logic signed [ACC_W-1:0] x, logic signed [ACC_W-1:0] xp,
         logic [3:0] sh);
      return x + ((x - xp) >>> sh);
   endfunction

   // -------------------------------------------------
   // bus handshakes and outputs
   // -------------------------------------------------
   assign s_axi_awready = !s.aw_got && !s.bvalid;
   assign s_axi_wready = !s.w_got && !s.bvalid;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = !s.rvalid;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign adc_ready = fifo_in_ready;
   assign gain_step = s.gain;
   assign polar = s.pol;
   assign polar_valid = s.pvalid;
   assign trace_point = s.trace;
   assign trace_valid = s.tvalid;

   // -------------------------------------------------
   // next state
   // -------------------------------------------------
   always_comb begin
      logic [31:0] wv;
      logic adv;
      logic [1:0] gd;
      logic signed [ACC_W-1:0] xc;
      logic signed [ACC_W-1:0] bi;
      logic signed [ACC_W-1:0] bq;
      logic [8:0] alpha;
      logic [7:0] dec_eff;
      logic [ACC_W-1:0] ai;
      logic [ACC_W-1:0] aq;
      logic [ACC_W-1:0] mx;
      logic [ACC_W-1:0] mn;
      logic [ACC_W-1:0] mag;
      logic [MAG_HI-1:0] mh;
      logic [ACC_W-1:0] sv;
      logic signed [ACC_W:0] vd;
      logic [ACC_W-1:0] dv;
      dif_det_t em;
      logic [31:0] acc;
      logic [ACC_W-1:0] res;
      wv = '0;
      adv = adc_valid && fifo_in_ready;
      gd = s.gpipe[AR_ALIGN-1];
      xc = '0;
      bi = '0;
      bq = '0;
      alpha = RBW_STEPS - {1'b0, s.resolution_filter_width};
      dec_eff = (s.decim == '0) ? DECIM_RST : s.decim;
      ai = '0;
      aq = '0;
      mx = '0;
      mn = '0;
      mag = '0;
      mh = '0;
      sv = '0;
      vd = '0;
      dv = '0;
      em = s.accum ? DET_AVG : s.dmode;
      acc = '0;
      res = '0;
      fifo_push = 1'b0;
      fifo_in = '0;
      next_s = s;
      next_s.pvalid = 1'b0;
      next_s.tvalid = 1'b0;

      // register writes and reads
      if (s_axi_awvalid && !s.aw_got && !s.bvalid) begin
         next_s.aw_got = 1'b1;
         next_s.waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s.w_got && !s.bvalid) begin
         next_s.w_got = 1'b1;
         next_s.wdata = s_axi_wdata;
         next_s.wstrb = s_axi_wstrb;
      end
      if (s.aw_got && s.w_got && !s.bvalid) begin
         wv = wmerge(reg_read(s, s.waddr, !fifo_in_ready), s.wdata,
            s.wstrb);
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = reg_ok(s.waddr) ? RESP_OKAY : RESP_SLVERR;
         case (s.waddr)
            REG_CTRL: begin
               next_s.ar_en = wv[CTRL_AR_EN];
               next_s.swept = wv[CTRL_SWEPT];
               next_s.vmode = dif_vmode_t'(wv[CTRL_VMODE +: 2]);
               next_s.dmode = dif_det_t'(wv[CTRL_DMODE +: 2]);
               next_s.accum = wv[CTRL_ACCUM];
            end
            REG_RBW: begin // see [R9]
               next_s.resolution_filter_width = (wv[7:0] > RBW_LAST) ? RBW_LAST : wv[7:0];
            end
            REG_DECIM: next_s.decim = wv[7:0]; // see [R10]
            REG_VIDEO: next_s.vshift = wv[3:0];
            REG_BUCKET: next_s.bl = wv[2:0];
            REG_BOOST: next_s.boost = wv[3:0];
            default: ;
         endcase
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      if (s_axi_arvalid && !s.rvalid) begin
         next_s.rvalid = 1'b1;
         next_s.rdata = reg_read(s, s_axi_araddr, !fifo_in_ready);
         next_s.rresp = reg_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end

      // autorange, one step per cycle while warned
      if (s.ar_en && s.swept) begin // see [R4]
         if (env_big) begin
            next_s.hold = '0;
            if (s.gain != '0) begin
               next_s.gain = s.gain - 1'b1; // see [R1]
            end
         end else if (s.hold == HOLD_W'(AR_HOLD_CYC - 1)) begin
            next_s.hold = '0;
            if (s.gain != GAIN_MAX) begin
               next_s.gain = s.gain + 1'b1; // see [R2]
            end
         end else begin
            next_s.hold = s.hold + 1'b1;
         end
      end else begin
         next_s.gain = GAIN_DIS;
         next_s.hold = '0;
      end
      next_s.gpipe = {s.gpipe[AR_ALIGN-2:0], next_s.gain};

      // gain correction, mixing, filtering
      if (adv) begin
         xc = ACC_W'(signed'(adc_data)) <<< (GAIN_MAX - gd); // see [R3]
         next_s.ph = s.ph + 1'b1;
         case (s.ph) // see [R5]
            2'h0: next_s.i_hold = xc;
            2'h2: next_s.i_hold = -xc;
            default: next_s.i_hold = s.i_hold;
         endcase
         if (s.ph[0]) begin
            bq = (s.ph == 2'h1) ? -xc : xc;
            bi = boostf(s.i_hold, s.bi_prev, s.boost); // see [R6]
            bq = boostf(bq, s.bq_prev, s.boost);
            next_s.bi_prev = s.i_hold;
            next_s.bq_prev = (s.ph == 2'h1) ? -xc : xc;
            for (int k = 0; k < GAUSS_N; k++) begin // see [R7] [R8]
               next_s.gi[k] = gsmooth(s.gi[k],
                  (k == 0) ? bi : s.gi[k-1], alpha);
               next_s.gq[k] = gsmooth(s.gq[k],
                  (k == 0) ? bq : s.gq[k-1], alpha);
            end
            if (s.dcnt >= dec_eff - 1'b1) begin // see [R10] [R11]
               next_s.dcnt = '0;
               fifo_push = 1'b1; // see [R16]
               fifo_in.i = next_s.gi[GAUSS_N-1][IQ_LSB +: IQ_W];
               fifo_in.q = next_s.gq[GAUSS_N-1][IQ_LSB +: IQ_W];
            end else begin
               next_s.dcnt = s.dcnt + 1'b1;
            end
            if (s.swept) begin
               ai = next_s.gi[GAUSS_N-1];
               aq = next_s.gq[GAUSS_N-1];
               ai = ai[ACC_W-1] ? -ai : ai;
               aq = aq[ACC_W-1] ? -aq : aq;
               mx = (ai > aq) ? ai : aq;
               mn = (ai > aq) ? aq : ai;
               mag = mx + (mn >> 1);
               next_s.pol.mag = mag; // see [R12]
               next_s.pol.phase = {next_s.gi[GAUSS_N-1][ACC_W-1],
                  next_s.gq[GAUSS_N-1][ACC_W-1], aq > ai,
                  mn > (mx >> 1)};
               next_s.pvalid = 1'b1;
               mh = mag[ACC_W-1 -: MAG_HI];
               case (s.vmode) // see [R15]
                  VID_LOG: sv = ACC_W'(log2a(mag));
                  VID_VOLT: sv = mag;
                  VID_POWER: sv = ACC_W'(mh * mh);
                  default: sv = mag;
               endcase
               vd = (ACC_W+1)'(sv) - (ACC_W+1)'(s.vfilt);
               next_s.vfilt = s.vfilt + ACC_W'(vd >>> s.vshift); // see [R13]
               dv = s.accum ? sv : next_s.vfilt; // see [R15]
               if (s.bcnt == '0) begin
                  acc = 32'(dv);
               end else begin
                  case (em)
                     DET_PEAK: acc = (32'(dv) > s.dacc) ? 32'(dv) : s.dacc;
                     DET_NEG: acc = (32'(dv) < s.dacc) ? 32'(dv) : s.dacc;
                     DET_SAMPLE: acc = 32'(dv);
                     DET_AVG: acc = s.dacc + 32'(dv);
                     default: acc = 32'(dv);
                  endcase
               end
               next_s.dacc = acc;
               if (s.bcnt == 8'((9'h001 << s.bl) - 9'h001)) begin
                  res = (em == DET_AVG) ? ACC_W'(acc >> s.bl)
                     : acc[ACC_W-1:0];
                  next_s.trace = to_log(res, s.vmode); // see [R13]
                  next_s.tvalid = 1'b1; // see [R16]
                  next_s.bcnt = '0;
               end else begin
                  next_s.bcnt = s.bcnt + 1'b1;
               end
            end
         end
      end
   end

   // -------------------------------------------------
   // state register
   // -------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         s <= '0; // see [R16]
         s.decim <= DECIM_RST;
         s.vshift <= VSHIFT_RST;
         s.boost <= BOOST_RST;
      end else begin
         s <= next_s;
      end
   end

   // -------------------------------------------------
   // decimated pair buffer
   // -------------------------------------------------
   dif_fifo #(
      .W($bits(dif_iq_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .in_data(fifo_in),
      .in_valid(fifo_push),
      .in_ready(fifo_in_ready),
      .out_data(iq_data),
      .out_valid(iq_valid),
      .out_ready(iq_ready)
   );
endmodule
`default_nettype wire

// ==== dif_pkg.sv ====
`default_nettype none
package dif_pkg;
   // -------------------------------------------------
   // timing
   // -------------------------------------------------
   localparam int CLK_MHZ = 25;
   localparam int AR_HOLD_US = 100;
   localparam int AR_HOLD_CYC = AR_HOLD_US * CLK_MHZ;
   localparam int AR_ALIGN = 3;
   // -------------------------------------------------
   // widths and datapath constants
   // -------------------------------------------------
   localparam int ADC_W = 14;
   localparam int ACC_W = 24;
   localparam int IQ_W = 16;
   localparam int IQ_LSB = 4;
   localparam int HOLD_W = 12;
   localparam int GAUSS_N = 4;
   localparam int ALPHA_SH = 8;
   localparam int MAG_HI = 12;
   localparam logic [1:0] GAIN_MAX = 2'h3;
   localparam logic [1:0] GAIN_DIS = 2'h0;
   localparam logic [8:0] RBW_STEPS = 9'h0a0;
   localparam logic [7:0] RBW_LAST = 8'h9f;
   localparam logic [8:0] POW_LOG_OFS = 9'h0c0;
   // -------------------------------------------------
   // register map
   // -------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_RBW = 8'h04;
   localparam logic [7:0] REG_DECIM = 8'h08;
   localparam logic [7:0] REG_VIDEO = 8'h0c;
   localparam logic [7:0] REG_BUCKET = 8'h10;
   localparam logic [7:0] REG_BOOST = 8'h14;
   localparam logic [7:0] REG_STATUS = 8'h18;
   localparam logic [7:0] REG_TRACE = 8'h1c;
   localparam int CTRL_AR_EN = 0;
   localparam int CTRL_SWEPT = 1;
   localparam int CTRL_VMODE = 2;
   localparam int CTRL_DMODE = 4;
   localparam int CTRL_ACCUM = 6;
   localparam logic [7:0] DECIM_RST = 8'h01;
   localparam logic [3:0] VSHIFT_RST = 4'h4;
   localparam logic [3:0] BOOST_RST = 4'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // -------------------------------------------------
   // types
   // -------------------------------------------------
   typedef enum logic [1:0] {VID_LOG, VID_VOLT, VID_POWER} dif_vmode_t;
   typedef enum logic [1:0] {DET_PEAK, DET_NEG, DET_SAMPLE, DET_AVG} dif_det_t;
   typedef struct packed {
      logic signed [IQ_W-1:0] i;
      logic signed [IQ_W-1:0] q;
   } dif_iq_t;
   typedef struct packed {
      logic [ACC_W-1:0] mag;
      logic [3:0] phase;
   } dif_polar_t;
endpackage
`default_nettype wire

// ==== dif_fifo.sv ====
`default_nettype none
module dif_fifo #(
   parameter int W = 32,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } dif_fifo_st_t;
   dif_fifo_st_t s;
   dif_fifo_st_t next_s;
   logic push;
   logic pop;

   assign in_ready = (s.cnt != (AW+1)'(DEPTH));
   assign out_valid = (s.cnt != '0);
   assign out_data = s.mem[s.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wp] = in_data;
         next_s.wp = (s.wp == AW'(DEPTH-1)) ? '0 : s.wp + 1'b1;
      end
      if (pop) begin
         next_s.rp = (s.rp == AW'(DEPTH-1)) ? '0 : s.rp + 1'b1;
      end
      if (push && !pop) begin
         next_s.cnt = s.cnt + 1'b1;
      end else if (pop && !push) begin
         next_s.cnt = s.cnt - 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule
`default_nettype wire

// ==== dif_chain_chk.sv ====
`default_nettype none
module dif_chain_chk (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic env_big,
   input wire logic [1:0] gain_step,
   input wire dif_pkg::dif_iq_t iq_data,
   input wire logic iq_valid,
   input wire logic iq_ready,
   input wire logic polar_valid,
   input wire logic trace_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   import dif_pkg::*;
   logic [12:0] quiet;
   // -------------------------------------------------
   // cycles since last warning
   // -------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn || env_big) begin
         quiet <= 13'h0000;
      end else if (quiet != 13'h1fff) begin
         quiet <= quiet + 13'h0001;
      end
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence b_wait;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   chk_write_answer:
      assert property (wr_take |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   chk_bresp_hold:
      assert property (b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   chk_ready_block:
      assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("ready during response");
   chk_read_answer:
      assert property (rd_take |=> s_axi_rvalid)
      else $error("read data missing");
   chk_rdata_hold:
      assert property (s_axi_rvalid && !s_axi_rready |=>
         s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   chk_gain_lower:
      assert property (env_big && gain_step != 2'h0 |=>
         gain_step < $past(gain_step))
      else $error("gain not lowered");
   chk_gain_raise:
      assert property (gain_step > $past(gain_step) |->
         gain_step == $past(gain_step) + 2'h1 && quiet >= 13'h09c2)
      else $error("gain raised too early");
   chk_polar_pulse:
      assert property (polar_valid |=> !polar_valid)
      else $error("polar strobe too long");
   chk_trace_pulse:
      assert property (trace_valid |=> !trace_valid)
      else $error("trace strobe too long");
   chk_iq_hold:
      assert property (iq_valid && !iq_ready |=>
         iq_valid && $stable(iq_data))
      else $error("pair dropped while stalled");
endmodule
bind dif_chain dif_chain_chk chk (.*);
`default_nettype wire

// ==== dif_frontend_model.sv ====
`default_nettype none
module dif_frontend_model (
   input wire logic sys_clk,
   input wire logic adc_ready,
   output var logic [dif_pkg::ADC_W-1:0] adc_data,
   output var logic adc_valid,
   output var logic env_big
);
   timeunit 1ns;
   timeprecision 1ns;
   import dif_pkg::*;
   initial begin
      adc_data = '0;
      adc_valid = 1'b0;
      env_big = 1'b0;
   end
   // -------------------------------------------------
   // converter samples, held until taken
   // -------------------------------------------------
   task automatic push(input logic [ADC_W-1:0] d);
      adc_valid <= 1'b1;
      adc_data <= d;
      do @(posedge sys_clk); while (!adc_ready);
   endtask
   task automatic stop();
      adc_valid <= 1'b0;
      adc_data <= ~adc_data;
      @(posedge sys_clk);
   endtask
   // early warning ahead of the delayed large signal
   task automatic warn(input int n);
      env_big <= 1'b1;
      repeat (n) @(posedge sys_clk);
      env_big <= 1'b0;
      @(posedge sys_clk);
   endtask
endmodule
`default_nettype wire

// ==== digital_if_chain_test.sv ====
`default_nettype none
module digital_if_chain_test;
   timeunit 1ns;
   timeprecision 1ns;
   import dif_pkg::*;
   logic sys_clk = 1'b0;
   logic resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, iq_ready;
   logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, hold_iq;
   logic [7:0] s_axi_awaddr, s_axi_araddr, trace_point;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, gain_step;
   logic [ADC_W-1:0] adc_data;
   logic adc_valid, adc_ready, env_big, iq_valid, polar_valid, trace_valid;
   dif_iq_t iq_data;
   dif_polar_t polar;
   int err_total, tests_run, n_pair, n_polar, n_trace;
   int seed = 53914;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [32:0] iqq[$];
   logic [32:0] note;
   always #20 sys_clk = ~sys_clk;
   dif_chain #(.FIFO_DEPTH(8)) dut (.*);
   dif_frontend_model fe (.*);
   // -------------------------------------------------
   // compare and bus tasks
   // -------------------------------------------------
   task automatic cmp_bus(input string w, input logic [33:0] e, g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic cmp_iq(input dif_iq_t e, g);
      cmp_bus("iq_data", {2'h0, e}, {2'h0, g});
   endtask
   task automatic cmp_num(input string w, input logic [31:0] e, g);
      cmp_bus(w, {2'h0, e}, {2'h0, g});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      bq.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge sys_clk);
         if (!ad && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            ad = 1'b1;
         end
         if (!wd && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            wd = 1'b1;
         end
      end
      do @(posedge sys_clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r);
      rq.push_back({r, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge sys_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge sys_clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // -------------------------------------------------
   // output watcher
   // -------------------------------------------------
   always @(posedge sys_clk) begin
      if (resetn) begin
         if (s_axi_bvalid && s_axi_bready) begin
            cmp_num("bresp", 32'(bq.pop_front()),
               32'(s_axi_bresp));
         end
         if (s_axi_rvalid && s_axi_rready) begin
            cmp_bus("rdata", rq.pop_front(),
               {s_axi_rresp, s_axi_rdata});
         end
         if (iq_valid && iq_ready) begin
            n_pair++;
            note = iqq.pop_front();
            if (note[32]) cmp_iq(note[31:0], iq_data);
         end
         if (polar_valid) n_polar++;
         if (trace_valid) n_trace++;
      end
   end
   always @(posedge sys_clk) iq_ready <= !hold_iq && $random(seed) % 2 != 0;
   initial begin
      #(40000 * 40);
      err_total++;
      tally_and_finish();
   end
   // -------------------------------------------------
   // main sequence
   // -------------------------------------------------
   initial begin
      {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      hold_iq = 1'b1;
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      rd(REG_CTRL, 32'h0, RESP_OKAY);
      rd(REG_DECIM, 32'(DECIM_RST), RESP_OKAY);
      rd(REG_VIDEO, 32'(VSHIFT_RST), RESP_OKAY);
      rd(REG_BOOST, 32'(BOOST_RST), RESP_OKAY);
      rd(8'h20, 32'h0, RESP_SLVERR);
      rd(8'h02, 32'h0, RESP_SLVERR);
      wr(8'h24, 32'h1, RESP_SLVERR);
      wr(REG_STATUS, 32'hff, RESP_OKAY);
      rd(REG_STATUS, 32'h0, RESP_OKAY);
      wr(REG_RBW, 32'h0c8, RESP_OKAY);
      s_axi_wstrb <= 4'he;
      wr(REG_RBW, 32'h5, RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      rd(REG_RBW, 32'(RBW_LAST), RESP_OKAY);
      for (int v = 0; v < 3; v++) begin
         for (int d = 0; d < 5; d++) begin
            wr(REG_CTRL, 32'(v * 4 + d * 16), RESP_OKAY);
            rd(REG_CTRL, 32'(v * 4 + d * 16), RESP_OKAY);
         end
      end
      wr(REG_CTRL, 32'h0, RESP_OKAY);
      repeat (8) begin
         iqq.push_back(33'h100000000);
         fe.push('0);
         fe.push('0);
      end
      fe.stop();
      repeat (3) @(posedge sys_clk);
      cmp_num("adc_ready", 32'h0, 32'(adc_ready));
      rd(REG_STATUS, 32'h8, RESP_OKAY);
      hold_iq = 1'b0;
      repeat (100) @(posedge sys_clk);
      cmp_num("pairs", 32'h8, n_pair);
      cmp_num("polar idle", 32'h0, n_polar);
      wr(REG_DECIM, 32'h3, RESP_OKAY);
      wr(REG_BUCKET, 32'h0, RESP_OKAY);
      wr(REG_CTRL, 32'h2, RESP_OKAY);
      for (int i = 0; i < 24; i++) begin
         if (i % 6 == 5) iqq.push_back(33'h0);
         fe.push(ADC_W'($random(seed)));
      end
      fe.stop();
      repeat (100) @(posedge sys_clk);
      cmp_num("pairs", 32'hc, n_pair);
      cmp_num("polar", 32'hc, n_polar);
      cmp_num("trace", 32'hc, n_trace);
      wr(REG_CTRL, 32'h1, RESP_OKAY);
      repeat (2600) @(posedge sys_clk);
      cmp_num("gain", 32'h0, 32'(gain_step));
      wr(REG_CTRL, 32'h3, RESP_OKAY);
      repeat (3 * AR_HOLD_CYC + 100) @(posedge sys_clk);
      cmp_num("gain", 32'h3, 32'(gain_step));
      rd(REG_STATUS, 32'h7, RESP_OKAY);
      fe.warn(1);
      #1 cmp_num("gain", 32'h2, 32'(gain_step));
      fe.warn(5);
      #1 cmp_num("gain", 32'h0, 32'(gain_step));
      tally_and_finish();
   end
endmodule
`default_nettype wire
